/* rtl/mio_pkg.sv */
// Purpose: constants and types for the eight-bit shared i/o port
// Assumes: classic wishbone slave, 32-bit data, word-aligned registers
// Notes:   offsets of all registers are local choices
package mio_pkg;
  localparam int unsigned PORT_W = 8;
  localparam logic [7:0] OFS_PIN   = 8'h00;
  localparam logic [7:0] OFS_LATCH = 8'h04;
  localparam logic [7:0] OFS_DIR   = 8'h08;
  localparam logic [7:0] OFS_MODE  = 8'h0C;
  localparam logic [7:0] OFS_MEMCTL = 8'h10;
  localparam logic [7:0] OFS_SPCTL = 8'h14;
  localparam logic [7:0] DIR_RESET   = 8'hFF;
  localparam logic [7:0] LATCH_RESET = 8'h00;
  localparam logic [7:0] MEMCTL_RESET = 8'h80;
  localparam logic [7:0] SPCTL_RESET = 8'h00;
  localparam logic [7:0] MODE_RESET  = 8'h00;
  localparam int unsigned EXT_BUS_DISABLE_BIT = 7;
  localparam int unsigned SPEN_BIT  = 4;
  localparam int unsigned MODE_MCU_BIT = 0;
  localparam int unsigned MODE_CPS_BIT = 1;
  localparam int unsigned MODE_BIG_BIT = 2;
  localparam int unsigned BIT7 = 7;
  localparam int unsigned SP_RD_BIT = 0;
  localparam int unsigned SP_WR_BIT = 1;
  localparam int unsigned SP_CS_BIT = 2;
  localparam int unsigned NREG = 6;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } mio_pad_out_t;

  typedef struct packed {
    logic rd_en;
    logic wr_en;
    logic cs;
  } mio_sp_ctl_t;
endpackage

/* rtl/mio_port.sv */
// Purpose: eight-bit shared general purpose i/o port with wishbone registers
// Assumes: pad inputs synchronous to clk_i; one 100 MHz clock
// Notes:   pins are split into out/oe/in; the pad ring resolves the wire
//
// Added by the designer: the address map and the Wishbone slave port.
`timescale 1ns/100ps
`default_nettype none
module mio_port (
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  // wishbone classic slave
  input  wire logic                  cyc_i,
  input  wire logic                  stb_i,
  input  wire logic                  we_i,
  input  wire logic [7:0]            adr_i,
  input  wire logic [3:0]            sel_i,
  input  wire logic [31:0]           dat_i,
  output logic      [31:0]           dat_o,
  output logic                       ack_o,
  output logic                       err_o,
  // pads
  input  wire logic [7:0]            pin_i,
  output mio_pkg::mio_pad_out_t      pad_o,
  // alternate compare/capture channel two
  input  wire logic                  compare_capture_pwm_ch2_out_i,
  output logic                       compare_capture_pwm_ch2_capture_o,
  // external memory bus high byte
  input  wire logic [7:0]            ext_addr_data_high_byte_out_i,
  input  wire logic                  ext_addr_data_high_byte_oe_i,
  output logic      [7:0]            ext_addr_data_high_byte_in_o,
  // parallel slave port controls
  output mio_pkg::mio_sp_ctl_t       sp_ctl_o,
  output logic                       slave_port_enable_o
);
  import mio_pkg::*;

  // register copies steering the pin logic
  logic [7:0] latch_r;
  logic [7:0] direction_reg_r;
  logic [7:0] mode_r;
  logic [7:0] memory_control_reg_r;
  logic [7:0] slave_port_control_reg_r;
  logic [7:0] pin_samp_r;
  logic       ack_r;
  logic       rd_pend_r;
  logic       rd_pin_r;
  logic       err_r;

  // bus decode
  logic       req;
  logic       hit;
  logic [2:0] idx;
  logic       wr_lane;
  logic       mem_we;
  logic [7:0] mem_rdata;

  function automatic logic [2:0] ofs_to_idx(input logic [7:0] a);
    return a[4:2];
  endfunction

  assign req     = cyc_i && stb_i && !ack_r && !err_r && !rd_pend_r;
  assign idx     = ofs_to_idx(adr_i);
  assign hit     = (adr_i[1:0] == 2'b00) && (adr_i < 8'(NREG * 4));
  assign wr_lane = sel_i[0];
  assign mem_we  = req && hit && we_i && wr_lane;

  // the pin-level address shares the latch slot in storage
  logic [2:0] mem_widx;
  assign mem_widx = (adr_i == OFS_PIN) ? ofs_to_idx(OFS_LATCH) : idx;

  mio_regmem u_mem (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .we_i    (mem_we),
    .waddr_i (mem_widx),
    .wdata_i (dat_i[7:0]),
    .raddr_i (idx),
    .rdata_o (mem_rdata)
  );

  // shadow copies of control registers for the pin logic
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      latch_r                  <= LATCH_RESET;
      direction_reg_r          <= DIR_RESET;
      mode_r                   <= MODE_RESET;
      memory_control_reg_r     <= MEMCTL_RESET;
      slave_port_control_reg_r <= SPCTL_RESET;
    end else if (mem_we) begin
      unique case (adr_i)
        OFS_PIN, OFS_LATCH: latch_r <= dat_i[7:0];
        OFS_DIR:            direction_reg_r <= dat_i[7:0];
        OFS_MODE:           mode_r <= dat_i[7:0];
        OFS_MEMCTL:         memory_control_reg_r <= dat_i[7:0];
        OFS_SPCTL:          slave_port_control_reg_r <= dat_i[7:0];
        default:            latch_r <= latch_r;
      endcase
    end
  end

  // pin sampling, bit n is pin n
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_samp_r <= 8'h00;
    end else begin
      pin_samp_r <= pin_i;
    end
  end

  // answer: writes ack next cycle, reads wait for registered memory
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r     <= 1'b0;
      err_r     <= 1'b0;
      rd_pend_r <= 1'b0;
      rd_pin_r  <= 1'b0;
    end else begin
      ack_r     <= (req && hit && we_i) || rd_pend_r;
      err_r     <= req && !hit;
      rd_pend_r <= req && hit && !we_i;
      rd_pin_r  <= req && !we_i && (adr_i == OFS_PIN);
    end
  end

  // read data: pin level from samples, latch from storage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0000_0000;
    end else if (rd_pend_r) begin
      dat_o <= rd_pin_r ? {24'h00_0000, pin_samp_r} : {24'h00_0000, mem_rdata};
    end else begin
      dat_o <= 32'h0000_0000;
    end
  end

  assign ack_o = ack_r;
  assign err_o = err_r;

  // pin function selection
  logic       big_pkg;
  logic       bus_on;
  logic       ccp_on;
  logic       sp_on;
  logic [7:0] nxt_out;
  logic [7:0] nxt_oe;

  assign big_pkg = mode_r[MODE_BIG_BIT];
  assign bus_on  = big_pkg && !memory_control_reg_r[EXT_BUS_DISABLE_BIT];
  assign ccp_on  = mode_r[MODE_MCU_BIT] && !mode_r[MODE_CPS_BIT] && !bus_on;
  assign sp_on   = slave_port_control_reg_r[SPEN_BIT] && !bus_on;

  // per pin driver: memory bus first, then port with channel override
  always_comb begin
    nxt_out = latch_r;
    nxt_oe  = ~direction_reg_r;
    if (ccp_on && !direction_reg_r[BIT7]) begin
      nxt_out[BIT7] = compare_capture_pwm_ch2_out_i;
    end
    if (bus_on) begin
      nxt_out = ext_addr_data_high_byte_out_i;
      nxt_oe  = {8{ext_addr_data_high_byte_oe_i}};
    end
  end

  // registered pad and side outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pad_o.out                    <= 8'h00;
      pad_o.oe                     <= 8'h00;
      compare_capture_pwm_ch2_capture_o               <= 1'b0;
      ext_addr_data_high_byte_in_o <= 8'h00;
      sp_ctl_o                     <= '0;
      slave_port_enable_o          <= 1'b0;
    end else begin
      pad_o.out                    <= nxt_out;
      pad_o.oe                     <= nxt_oe;
      compare_capture_pwm_ch2_capture_o               <= ccp_on && direction_reg_r[BIT7] && pin_i[BIT7];
      ext_addr_data_high_byte_in_o <= bus_on ? pin_i : 8'h00;
      // direction is never forced; controls count only as inputs
      sp_ctl_o.rd_en <= sp_on && direction_reg_r[SP_RD_BIT] && pin_i[SP_RD_BIT];
      sp_ctl_o.wr_en <= sp_on && direction_reg_r[SP_WR_BIT] && pin_i[SP_WR_BIT];
      sp_ctl_o.cs    <= sp_on && direction_reg_r[SP_CS_BIT] && pin_i[SP_CS_BIT];
      slave_port_enable_o <= sp_on;
    end
  end
endmodule
`default_nettype wire

/* rtl/mio_regmem.sv */
// Purpose: small register store for the port, registered read data
// Assumes: one write port, one read port, same clock
// Notes:   read data lags the address by one clock
`timescale 1ns/100ps
`default_nettype none
module mio_regmem (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       we_i,
  input  wire logic [2:0] waddr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic [2:0] raddr_i,
  output logic      [7:0] rdata_o
);
  import mio_pkg::*;
  logic [7:0] mem_r [NREG];

  // storage; reset loads every entry with its register default
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mem_r[0] <= LATCH_RESET;
      mem_r[1] <= LATCH_RESET;
      mem_r[2] <= DIR_RESET;
      mem_r[3] <= MODE_RESET;
      mem_r[4] <= MEMCTL_RESET;
      mem_r[5] <= SPCTL_RESET;
    end else if (we_i && (waddr_i < 3'(NREG))) begin
      mem_r[waddr_i] <= wdata_i;
    end
  end

  // registered read port
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
    end else if (raddr_i < 3'(NREG)) begin
      rdata_o <= mem_r[raddr_i];
    end else begin
      rdata_o <= 8'h00;
    end
  end
endmodule
`default_nettype wire

/* testbench/mio_pins_model.sv */
// Purpose: outside circuitry on the eight port pins
// Assumes: outside drive never fights a driven pin
// Notes:   undriven pins take the outside value
`timescale 1ns/100ps
`default_nettype none
module mio_pins_model (
  input  wire mio_pkg::mio_pad_out_t pad_i,
  input  wire logic [7:0]            ext_i,
  output logic      [7:0]            pin_o
);
  import mio_pkg::*;
  // driven pins show the port, the rest the outside level
  assign pin_o = (pad_i.out & pad_i.oe) | (ext_i & ~pad_i.oe);
endmodule
`default_nettype wire

/* testbench/mio_port_properties.sv */
// Purpose: port-level assertions for the shared i/o port
// Assumes: one wishbone request open at a time
// Notes:   sees only the top-level ports
`timescale 1ns/100ps
`default_nettype none
module mio_port_properties (
  input wire logic                  clk_i,
  input wire logic                  rst_i,
  input wire logic                  cyc_i,
  input wire logic                  stb_i,
  input wire logic                  we_i,
  input wire logic [7:0]            adr_i,
  input wire logic [7:0]            pin_i,
  input wire mio_pkg::mio_pad_out_t pad_o,
  input wire logic                  ack_o,
  input wire logic                  err_o,
  input wire logic                  compare_capture_pwm_ch2_capture_o,
  input wire logic [7:0]            ext_addr_data_high_byte_in_o,
  input wire mio_pkg::mio_sp_ctl_t  sp_ctl_o,
  input wire logic                  slave_port_enable_o
);
  import mio_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // new requests; reads only to mapped, aligned places
  sequence s_wr;
    cyc_i && $rose(stb_i) && we_i;
  endsequence
  sequence s_rd;
    cyc_i && $rose(stb_i) && !we_i && adr_i <= OFS_SPCTL && adr_i[1:0] == 2'h0;
  endsequence
  a_write_answer: assert property (s_wr |=> ack_o || err_o)
    else $error("write not answered next cycle");
  a_read_answer: assert property (s_rd |=> !ack_o ##1 ack_o)
    else $error("read not answered in two cycles");
  a_reset_inputs: assert property ($fell(rst_i) |-> pad_o.oe == 8'h00)
    else $error("pin driven after reset");
  a_capture_pin: assert property (compare_capture_pwm_ch2_capture_o |-> $past(pin_i[BIT7]))
    else $error("capture not from pin");
  a_slave_gate: assert property (!slave_port_enable_o |-> sp_ctl_o == '0)
    else $error("slave control without slave mode");
  a_slave_pins: assert property (sp_ctl_o.cs |-> $past(pin_i[SP_CS_BIT]))
    else $error("chip select not from pin");
  a_ext_copy: assert property (ext_addr_data_high_byte_in_o != 8'h00
    |-> ext_addr_data_high_byte_in_o == $past(pin_i))
    else $error("bus byte not from pins");
  a_ext_wins: assert property (ext_addr_data_high_byte_in_o != 8'h00
    |-> !slave_port_enable_o && !compare_capture_pwm_ch2_capture_o)
    else $error("other use active with bus on");
endmodule
bind mio_port mio_port_properties mio_port_properties_i (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
  .adr_i(adr_i), .pin_i(pin_i), .pad_o(pad_o), .ack_o(ack_o), .err_o(err_o),
  .compare_capture_pwm_ch2_capture_o(compare_capture_pwm_ch2_capture_o), .sp_ctl_o(sp_ctl_o),
  .ext_addr_data_high_byte_in_o(ext_addr_data_high_byte_in_o),
  .slave_port_enable_o(slave_port_enable_o));
`default_nettype wire

/* testbench/mio_port_tb.sv */
// Purpose: self-checking bench for the shared i/o port
// Assumes: one request at a time on the register bus
// Notes:   bus answers are queued, a monitor checks them
`timescale 1ns/100ps
`default_nettype none
module mio_port_tb;
  import mio_pkg::*;
  logic         clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, err_o;
  logic         compare_capture_pwm_ch2_out_i, cap, sp_en, x_oe;
  logic [7:0]   adr_i, pin_i, ext_v, x_out, x_in, l, d;
  logic [31:0]  dat_i, dat_o;
  logic [3:0]   sel_i;
  logic [9:0]   nt;
  logic [9:0]   q[$];
  mio_pad_out_t pad_o;
  mio_sp_ctl_t  sp;
  int           failures, n_tests;
  integer       seed;
  mio_port mio_port_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
    .ack_o(ack_o), .err_o(err_o), .pin_i(pin_i), .pad_o(pad_o),
    .compare_capture_pwm_ch2_out_i(compare_capture_pwm_ch2_out_i), .compare_capture_pwm_ch2_capture_o(cap),
    .ext_addr_data_high_byte_out_i(x_out), .ext_addr_data_high_byte_oe_i(x_oe),
    .ext_addr_data_high_byte_in_o(x_in), .sp_ctl_o(sp), .slave_port_enable_o(sp_en));
  mio_pins_model mio_pins_model_i (.pad_i(pad_o), .ext_i(ext_v), .pin_o(pin_i));
  task cmp(input string n, input logic [8:0] e, input logic [8:0] g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask
  // one classic cycle, held until answered
  task bus(input logic w, input logic [7:0] a, input logic [7:0] v, input logic [9:0] e);
    @(posedge clk_i);
    q.push_back(e);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= {24'h000000, v};
    do @(posedge clk_i); while (!(ack_o || err_o));
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task wr(input logic [7:0] a, input logic [7:0] v);
    bus(1'b1, a, v, 10'h000);
  endtask
  task rd(input logic [7:0] a, input logic [8:0] e);
    bus(1'b0, a, 8'h00, {1'b1, e});
  endtask
  // pads settle two edges after a write
  task wt;
    repeat (3) @(posedge clk_i);
    #1;
  endtask
  task finish_test;
    $display("tests %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // oldest note against each answer; data only on reads
  always @(posedge clk_i) begin
    if (ack_o || err_o) begin
      nt = q.pop_front();
      cmp("resp", nt[8:0], {err_o, nt[9] ? dat_o[7:0] : nt[7:0]});
    end
  end
  // a hang would never reach the verdict
  initial begin
    repeat (3000) @(posedge clk_i);
    failures++;
    finish_test;
  end
  initial begin
    {rst_i, cyc_i, stb_i, we_i, compare_capture_pwm_ch2_out_i, x_oe} <= 6'h20;
    {adr_i, ext_v, x_out, dat_i} <= '0;
    sel_i <= 4'hF;
    seed = 32'h0684;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(OFS_DIR, {1'b0, DIR_RESET});
    cmp("oe", 9'h000, {1'b0, pad_o.oe});
    rd(OFS_MEMCTL, {1'b0, MEMCTL_RESET});
    rd(8'h40, 9'h100);
    for (int i = 0; i < 6; i++) begin
      l = 8'($random(seed));
      d = 8'($random(seed));
      ext_v <= 8'($random(seed));
      wr(OFS_LATCH, l);
      wr(OFS_DIR, d);
      wt;
      cmp("oe", {1'b0, ~d}, {1'b0, pad_o.oe});
      cmp("out", {1'b0, l & ~d}, {1'b0, pad_o.out & ~d});
      rd(OFS_LATCH, {1'b0, l});
      rd(OFS_PIN, {1'b0, (l & ~d) | (ext_v & d)});
    end
    wr(OFS_PIN, 8'h3C);
    rd(OFS_LATCH, 9'h03C);
    // low byte lane off: write is answered but must not store
    sel_i <= 4'hE;
    wr(OFS_LATCH, 8'hFF);
    sel_i <= 4'hF;
    rd(OFS_LATCH, 9'h03C);
    wr(OFS_DIR, 8'h7F);
    wr(OFS_MODE, 8'h01);
    compare_capture_pwm_ch2_out_i <= 1'b1;
    wt;
    cmp("bit7", 9'h001, {8'h00, pad_o.out[7]});
    wr(OFS_DIR, 8'hFF);
    ext_v <= 8'h80;
    wt;
    cmp("cap", 9'h001, {8'h00, cap});
    wr(OFS_MODE, 8'h03);
    wt;
    cmp("cap", 9'h000, {8'h00, cap});
    wr(OFS_SPCTL, 8'h10);
    wr(OFS_MEMCTL, 8'h00);
    x_oe <= 1'b1;
    x_out <= 8'h5A;
    wt;
    cmp("oe", 9'h000, {1'b0, pad_o.oe});
    wr(OFS_MODE, 8'h04);
    wt;
    cmp("bus", 9'h15A, {&pad_o.oe, pad_o.out});
    cmp("spen", 9'h000, {8'h00, sp_en});
    @(posedge clk_i);
    x_oe <= 1'b0;
    wt;
    cmp("ext_in", 9'h080, {1'b0, x_in});
    wr(OFS_MEMCTL, 8'h80);
    ext_v <= 8'h03;
    wt;
    cmp("sp", 9'h006, {6'h00, sp});
    wr(OFS_DIR, 8'hF8);
    wt;
    cmp("sp", 9'h107, {sp_en, sp, 2'b00, pad_o.oe[2:0]});
    // mid-run reset with pins driven and slave mode on
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    #1;
    cmp("oe", 9'h000, {1'b0, pad_o.oe});
    cmp("spen", 9'h000, {8'h00, sp_en});
    rd(OFS_DIR, {1'b0, DIR_RESET});
    rd(OFS_LATCH, {1'b0, LATCH_RESET});
    finish_test;
  end
endmodule
`default_nettype wire
